// ---- hdl/smtw_ctrl.sv ----
// Single-master two-wire serial controller: queues, bit engine, pads.
// Assumes open-drain pads outside, with pull-ups on SCL and SDA.
`timescale 1ns/1ps
module smtw_ctrl
    import smtw_pkg::*;
(
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    input  wire logic             i_serial_bus_clock_gate,
    input  wire logic             i_soft_reset,
    input  wire logic [DIV_W-1:0] i_clk_hi,
    input  wire logic [DIV_W-1:0] i_clk_lo,
    input  wire logic             i_tx_valid,
    input  wire logic [TX_W-1:0]  i_tx_data,
    output logic                  o_tx_ready,
    output logic                  o_rx_valid,
    output logic [RX_W-1:0]       o_rx_data,
    input  wire logic             i_rx_ready,
    input  wire logic             i_irq_clear,
    output logic                  o_irq,
    output logic                  o_nack_err,
    output logic                  o_done,
    output logic                  o_busy,
    output logic                  o_tx_empty,
    output logic                  o_rx_full,
    output logic                  o_scl_level,
    output logic                  o_sda_level,
    input  wire logic             i_scl_in,
    output logic                  o_scl_out,
    output logic                  o_scl_oe,
    input  wire logic             i_sda_in,
    output logic                  o_sda_out,
    output logic                  o_sda_oe
);

    smtw_core_t q;
    smtw_core_t n;
    logic       stretch;
    logic       tick;
    logic       phase_end;
    logic       nack_now;

    smtw_fifo_if #(.W(TX_W)) tx ();
    smtw_fifo_if #(.W(RX_W)) rx ();

    // ==========================================================
    // Queues
    smtw_fifo #(.W(TX_W)) u_tx_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .f         (tx)
    );

    smtw_fifo #(.W(RX_W)) u_rx_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .f         (rx)
    );

    assign tx.w_valid = i_tx_valid;
    assign tx.w_data  = i_tx_data;
    assign tx.flush   = i_soft_reset;
    assign rx.flush   = i_soft_reset;
    assign rx.r_ready = i_rx_ready;
    assign rx.w_data  = q.rx_byte;
    assign o_tx_ready = tx.w_ready;
    assign o_rx_valid = rx.r_valid;
    assign o_rx_data  = rx.r_data;

    // ==========================================================
    // Outputs
    assign o_scl_out   = 1'b0;
    assign o_sda_out   = 1'b0;
    assign o_scl_oe    = q.scl_oe;
    assign o_sda_oe    = q.sda_oe;
    assign o_scl_level = q.scl_s2;
    assign o_sda_level = q.sda_s2;
    assign o_nack_err  = q.nack_err;
    assign o_done      = q.done;
    assign o_irq       = q.nack_err | q.done;
    assign o_busy      = (q.st != ST_IDLE);
    assign o_tx_empty  = !tx.r_valid;
    assign o_rx_full   = !rx.w_ready;

    // Load one queue entry into the shifter; read entries ignore their data
    function automatic smtw_core_t load_entry(input smtw_core_t s, input logic [TX_W-1:0] e,
                                              input logic addr);
        smtw_core_t r;
        r          = s;
        r.cur_stop = e[TX_STOP_BIT];
        r.is_addr  = addr;
        r.bitn     = '0;
        if (addr) begin
            r.rd_mode = e[0];
        end
        r.rd_byte  = !addr && r.rd_mode;
        r.sh       = r.rd_byte ? RD_SHIFT_INIT : {e[7:0], 1'b1};
        r.sda_oe   = !r.sh[8];
        return r;
    endfunction : load_entry

    // ==========================================================
    // Bit engine
    always_comb begin
        n          = q;
        tx.r_ready = 1'b0;
        rx.w_valid = 1'b0;
        n.scl_s1   = i_scl_in;
        n.scl_s2   = q.scl_s1;
        n.sda_s1   = i_sda_in;
        n.sda_s2   = q.sda_s1;
        // Restart pending in the queue means this read byte is the last one
        nack_now   = q.cur_stop | (tx.r_valid & tx.r_data[TX_START_BIT]);
        // Released SCL still low: a slave is stretching, so the count waits
        stretch    = !q.scl_oe && !q.scl_s2 && (q.st != ST_IDLE);
        tick       = i_serial_bus_clock_gate && !stretch;
        phase_end  = tick && (q.cnt == '0);
        // Clear loses to a set in the same cycle
        n.nack_err = q.nack_err & ~i_irq_clear;
        n.done     = q.done & ~i_irq_clear;
        if (tick && q.cnt != '0) begin
            n.cnt = q.cnt - 1'b1;
        end
        if (q.rx_pend && rx.w_ready) begin
            rx.w_valid = 1'b1;
            n.rx_pend  = 1'b0;
        end
        if (i_soft_reset) begin
            n.st      = ST_IDLE;
            n.scl_oe  = 1'b0;
            n.sda_oe  = 1'b0;
            n.rx_pend = 1'b0;
            n.cnt     = '0;
        end else begin
            case (q.st)
                ST_IDLE: begin
                    // Bus is ours alone, so no busy check before a START
                    if (i_serial_bus_clock_gate && tx.r_valid && !q.rx_pend) begin
                        tx.r_ready = 1'b1;
                        n          = load_entry(n, tx.r_data, 1'b1);
                        n.sda_oe   = 1'b1;
                        n.cnt      = smtw_phase_len(i_clk_hi);
                        n.st       = ST_START;
                    end
                end
                ST_START: begin
                    if (phase_end) begin
                        n.scl_oe = 1'b1;
                        n.cnt    = smtw_phase_len(i_clk_lo);
                        n.st     = ST_LOW;
                    end
                end
                ST_LOW: begin
                    // SDA moves a cycle after SCL fell and never on the release edge
                    if (phase_end) begin
                        n.scl_oe = 1'b0;
                        n.cnt    = smtw_phase_len(i_clk_hi);
                        n.st     = ST_HIGH;
                    end else if (q.rd_byte && q.bitn == LAST_BIT) begin
                        n.sda_oe = !nack_now;
                    end else begin
                        n.sda_oe = !q.sh[8];
                    end
                end
                ST_HIGH: begin
                    if (phase_end) begin
                        n.rxsh   = {q.rxsh[7:0], q.sda_s2};
                        n.scl_oe = 1'b1;
                        n.cnt    = smtw_phase_len(i_clk_lo);
                        if (q.bitn == LAST_BIT) begin
                            n.bitn    = '0;
                            n.is_addr = 1'b0;
                            if (!q.rd_byte && q.sda_s2) begin
                                n.nack_err = 1'b1;
                            end
                            if (q.rd_byte) begin
                                n.rx_byte = q.rxsh[7:0];
                                n.rx_pend = 1'b1;
                            end
                            // SDA untouched on this edge, else a false START or STOP
                            n.st     = q.cur_stop ? ST_STOP_LOW : ST_HOLD;
                        end else begin
                            n.bitn = q.bitn + 1'b1;
                            n.sh   = {q.sh[7:0], 1'b1};
                            n.st   = ST_LOW;
                        end
                    end
                end
                ST_HOLD: begin
                    // SCL stays low: the bus remains owned while the queue is refilled
                    // Ack released a cycle after SCL fell, ready for a restart
                    n.sda_oe = 1'b0;
                    if (i_serial_bus_clock_gate && !q.rx_pend && tx.r_valid) begin
                        n.cnt = smtw_phase_len(i_clk_lo);
                        if (tx.r_data[TX_START_BIT]) begin
                            n.st = ST_RESTART;
                        end else begin
                            tx.r_ready = 1'b1;
                            n          = load_entry(n, tx.r_data, 1'b0);
                            n.st       = ST_LOW;
                        end
                    end
                end
                ST_RESTART: begin
                    if (phase_end) begin
                        n.scl_oe = 1'b0;
                        n.cnt    = smtw_phase_len(i_clk_hi);
                        n.st     = ST_RS_HIGH;
                    end
                end
                ST_RS_HIGH: begin
                    if (phase_end && tx.r_valid) begin
                        tx.r_ready = 1'b1;
                        n          = load_entry(n, tx.r_data, 1'b1);
                        n.sda_oe   = 1'b1;
                        n.cnt      = smtw_phase_len(i_clk_hi);
                        n.st       = ST_START;
                    end
                end
                ST_STOP_LOW: begin
                    if (phase_end) begin
                        n.scl_oe = 1'b0;
                        n.cnt    = smtw_phase_len(i_clk_hi);
                        n.st     = ST_STOP_HIGH;
                    end else begin
                        n.sda_oe = 1'b1;
                    end
                end
                ST_STOP_HIGH: begin
                    if (phase_end) begin
                        n.sda_oe = 1'b0;
                        n.done   = 1'b1;
                        n.cnt    = smtw_phase_len(i_clk_hi);
                        n.st     = ST_STOP_END;
                    end
                end
                ST_STOP_END: begin
                    if (phase_end) begin
                        n.st = ST_IDLE;
                    end
                end
                default: begin
                    n.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_idle_released: assert property (q.st == ST_IDLE |-> !o_scl_oe && !o_sda_oe)
        else $error("lines driven while idle");
    a_phase_min_len: assert property ($changed(q.st) && q.st inside {ST_LOW, ST_HIGH} |-> q.cnt >= MIN_PHASE_CYC - 1'b1)
        else $error("scl phase shorter than the top rate allows");
    a_stretch_holds: assert property (q.st == ST_HIGH && !q.scl_s2 && !o_scl_oe && !i_soft_reset |=> q.st == ST_HIGH && q.cnt == $past(q.cnt))
        else $error("high phase advanced while scl held low");
    a_gate_freeze: assert property (!i_serial_bus_clock_gate && !i_soft_reset && q.st != ST_IDLE |=> $stable(q.st) && $stable(q.cnt))
        else $error("engine moved with clock gate off");
    a_start_cond: assert property ($rose(o_sda_oe) && !o_scl_oe |-> q.st == ST_START && $past(q.st) inside {ST_IDLE, ST_RS_HIGH})
        else $error("sda fell with scl high outside a start");
    a_stop_cond: assert property (q.st == ST_STOP_HIGH && phase_end && !i_soft_reset |=> !o_sda_oe && !o_scl_oe && o_done)
        else $error("stop condition not produced");
    a_hold_owned: assert property (q.st == ST_HOLD |-> o_scl_oe)
        else $error("scl released between bytes");
    a_dir_latched: assert property (q.is_addr && q.st inside {ST_LOW, ST_HIGH} && q.bitn < LAST_BIT |-> q.rd_mode == q.sh[4'h1 + q.bitn])
        else $error("direction does not follow address bit");
    a_msb_first: assert property (q.st == ST_HIGH && !q.rd_byte && q.bitn < LAST_BIT |-> o_sda_oe == !q.sh[8])
        else $error("write bit not taken from shifter top");
    a_last_nack: assert property (q.st inside {ST_LOW, ST_HIGH} && q.rd_byte && q.bitn == LAST_BIT && q.cur_stop |-> !o_sda_oe)
        else $error("final read byte was acknowledged");
    a_read_released: assert property (q.st == ST_HIGH && q.rd_byte && q.bitn < LAST_BIT |-> !o_sda_oe)
        else $error("sda driven during a read data bit");

    c_restart: cover property (q.st == ST_RESTART ##[1:1000] q.st == ST_START);
    c_stretch: cover property (stretch && q.st == ST_HIGH);
    c_read_done: cover property (rx.w_valid && rx.w_ready);
    c_write_nack: cover property ($rose(q.nack_err));

endmodule : smtw_ctrl

// ---- hdl/smtw_pkg.sv ----
// Constants, state types and shared helpers of the two-wire master.
// Assumes a single 50 MHz system clock and open-drain pads outside.
package smtw_pkg;

    // ==========================================================
    // Clock and bus rate
    localparam int              CLK_HZ        = 50_000_000;
    localparam int              BUS_MAX_HZ    = 400_000;
    localparam int              DIV_W         = 16;
    // Shortest SCL half period, rounded up, keeps the bus at or below the top rate
    localparam logic [DIV_W-1:0] MIN_PHASE_CYC = DIV_W'((CLK_HZ / BUS_MAX_HZ + 1) / 2);

    // ==========================================================
    // Queues
    localparam int              FIFO_DEPTH    = 4;
    localparam int              PTR_W         = 2;
    localparam int              CNT_W         = 3;
    localparam int              TX_W          = 10;
    localparam int              RX_W          = 8;
    localparam int              TX_START_BIT  = 8;
    localparam int              TX_STOP_BIT   = 9;

    // ==========================================================
    // Byte framing
    localparam logic [3:0]      LAST_BIT      = 4'h8;
    localparam logic [8:0]      RD_SHIFT_INIT = 9'h1FF;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START,
        ST_LOW,
        ST_HIGH,
        ST_HOLD,
        ST_RESTART,
        ST_RS_HIGH,
        ST_STOP_LOW,
        ST_STOP_HIGH,
        ST_STOP_END
    } smtw_state_t;

    typedef struct packed {
        logic              scl_s1;
        logic              scl_s2;
        logic              sda_s1;
        logic              sda_s2;
        smtw_state_t       st;
        logic [DIV_W-1:0]  cnt;
        logic [3:0]        bitn;
        logic [8:0]        sh;
        logic [8:0]        rxsh;
        logic              cur_stop;
        logic              is_addr;
        logic              rd_mode;
        logic              rd_byte;
        logic              scl_oe;
        logic              sda_oe;
        logic              rx_pend;
        logic [RX_W-1:0]   rx_byte;
        logic              nack_err;
        logic              done;
    } smtw_core_t;

    // Phase length minus one, never below the fastest legal half period
    function automatic logic [DIV_W-1:0] smtw_phase_len(input logic [DIV_W-1:0] div);
        logic [DIV_W-1:0] d;
        d = (div < MIN_PHASE_CYC) ? MIN_PHASE_CYC : div;
        return d - 1'b1;
    endfunction : smtw_phase_len

endpackage : smtw_pkg

// ---- hdl/smtw_fifo_if.sv ----
// Valid/ready queue connection between the controller and its FIFOs.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface smtw_fifo_if #(parameter int W = 8);
    logic         w_valid;
    logic         w_ready;
    logic [W-1:0] w_data;
    logic         r_valid;
    logic         r_ready;
    logic [W-1:0] r_data;
    logic         flush;
    logic [2:0]   count;

    modport fifo (input w_valid, w_data, r_ready, flush, output w_ready, r_valid, r_data, count);
    modport user (output w_valid, w_data, r_ready, flush, input w_ready, r_valid, r_data, count);
endinterface : smtw_fifo_if

// ---- hdl/smtw_fifo.sv ----
// Four-entry first-in first-out queue with valid/ready on both sides.
// Assumes writer and reader obey valid/ready; flush empties it at once.
`timescale 1ns/1ps
module smtw_fifo
    import smtw_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    smtw_fifo_if.fifo f
);

    typedef struct packed {
        logic [FIFO_DEPTH-1:0][W-1:0] mem;
        logic [PTR_W-1:0]             wp;
        logic [PTR_W-1:0]             rp;
        logic [CNT_W-1:0]             cnt;
    } smtw_fifo_st_t;

    smtw_fifo_st_t q;
    smtw_fifo_st_t d;
    logic          wr;
    logic          rd;

    assign f.w_ready = (q.cnt != CNT_W'(FIFO_DEPTH));
    assign f.r_valid = (q.cnt != '0);
    assign f.r_data  = q.mem[q.rp];
    assign f.count   = q.cnt;

    // ==========================================================
    // Next state
    always_comb begin
        d  = q;
        wr = f.w_valid & f.w_ready;
        rd = f.r_ready & f.r_valid;
        if (f.flush) begin
            d.wp  = '0;
            d.rp  = '0;
            d.cnt = '0;
        end else begin
            if (wr) begin
                d.mem[q.wp] = f.w_data;
                d.wp        = q.wp + 1'b1;
            end
            if (rd) begin
                d.rp = q.rp + 1'b1;
            end
            d.cnt = q.cnt + CNT_W'(wr) - CNT_W'(rd);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_fifo_bound: assert property (q.cnt <= CNT_W'(FIFO_DEPTH))
        else $error("fifo count above depth");
    a_fifo_full_block: assert property (q.cnt == CNT_W'(FIFO_DEPTH) && !rd && !f.flush |=> q.cnt == CNT_W'(FIFO_DEPTH))
        else $error("full fifo accepted a write");

endmodule : smtw_fifo

// ---- verification/smtw_slave_model.sv ----
// Behavioural slave chip on the two-wire bus: acks its address, keeps writes, serves reads.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module smtw_slave_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    input  wire logic [7:0]  i_rd_byte,
    input  wire logic [15:0] i_stretch_ns,
    output logic             o_scl_oe,
    output logic             o_sda_oe
);
    logic [7:0] sh;
    logic [7:0] rdb;
    logic       first, sel, rd_on, mack;
    logic [7:0] wr_q[$];
    int         bitc;

    initial begin
        {o_scl_oe, o_sda_oe, first, sel, rd_on, mack} = 6'h00;
        sh = 8'h00;
        rdb = 8'h00;
        bitc = 0;
    end

    // ==========================================================
    // Framing: START restarts the byte count
    always @(negedge i_sda) if (i_scl) begin
        bitc = 0;
        first = 1'b1;
        rd_on = 1'b0;
    end

    always @(posedge i_scl) begin
        if (bitc < 8) sh = {sh[6:0], i_sda};
        else if (rd_on) mack = !i_sda;
        bitc = bitc + 1;
    end

    // Lines change only while SCL is low, so no false START or STOP
    always @(negedge i_scl) begin
        if (bitc == 8) begin
            if (first) begin
                sel = (sh[7:1] == ADDR);
                rd_on = sel && sh[0];
                if (rd_on) mack = 1'b1;
                rdb = i_rd_byte;
                o_sda_oe = sel;
            end else if (!rd_on && sel) begin
                wr_q.push_back(sh);
                o_sda_oe = 1'b1;
            end else begin
                o_sda_oe = 1'b0;
            end
        end else if (bitc == 9) begin
            bitc = 0;
            if (rd_on && mack) begin
                if (!first) rdb = rdb + 8'h01;
                o_sda_oe = !rdb[7];
            end else begin
                rd_on = 1'b0;
                o_sda_oe = 1'b0;
            end
            first = 1'b0;
            if (i_stretch_ns != 16'h0000) begin
                o_scl_oe = 1'b1;
                #(i_stretch_ns);
                o_scl_oe = 1'b0;
            end
        end else if (rd_on && bitc > 0) begin
            o_sda_oe = !rdb[7-bitc];
        end
    end
endmodule : smtw_slave_model

// ---- verification/tb_single_master_two_wire_ctrl.sv ----
// Bench of the two-wire master: scenarios, wire monitor, slave model.
// Assumes pull-ups on both lines, modelled by the wired-and below.
`timescale 1ns/1ps
module tb_single_master_two_wire_ctrl;
    import smtw_pkg::*;
    // ==========================================================
    // Signals and bus
    logic                 clk, rst, gate, srst, txv, rxr, iclr;
    logic [DIV_W-1:0]     hi, lo;
    logic [TX_W-1:0]      txd;
    logic [15:0]          str;
    wire logic            tx_rdy, rx_v, irq, nerr, done, busy, txe, rxf, scl_lv, sda_lv;
    wire logic            scl_oe, sda_oe, s_scl_oe, s_sda_oe, scl_o, sda_o;
    wire logic [RX_W-1:0] rxd;
    wire logic            scl = !(scl_oe || s_scl_oe);
    wire logic            sda = !(sda_oe || s_sda_oe);
    int                   errors, num_checks, stops, starts, hi_ns, hi_min;
    realtime              t_up;

    smtw_ctrl i_dut (
        .i_sys_clk(clk), .i_rst(rst), .i_serial_bus_clock_gate(gate), .i_soft_reset(srst),
        .i_clk_hi(hi), .i_clk_lo(lo), .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(tx_rdy),
        .o_rx_valid(rx_v), .o_rx_data(rxd), .i_rx_ready(rxr), .i_irq_clear(iclr), .o_irq(irq),
        .o_nack_err(nerr), .o_done(done), .o_busy(busy), .o_tx_empty(txe), .o_rx_full(rxf),
        .o_scl_level(scl_lv), .o_sda_level(sda_lv), .i_scl_in(scl), .o_scl_out(scl_o), .o_scl_oe(scl_oe),
        .i_sda_in(sda), .o_sda_out(sda_o), .o_sda_oe(sda_oe)
    );
    smtw_slave_model i_slave (
        .i_scl(scl), .i_sda(sda), .i_rd_byte(8'h3C), .i_stretch_ns(str),
        .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe)
    );

    // ==========================================================
    // Wire monitor: conditions and SCL high time
    always @(posedge sda) if (scl) stops++;
    always @(negedge sda) if (scl) starts++;
    always @(posedge scl) t_up = $realtime;
    always @(negedge scl) begin
        hi_ns = int'($realtime - t_up);
        if (hi_ns < hi_min) hi_min = hi_ns;
    end

    // ==========================================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic push(input logic [TX_W-1:0] d[4]);
        foreach (d[i]) begin
            txv = 1'b1;
            txd = d[i];
            tick(1);
        end
        txv = 1'b0;
    endtask : push

    task automatic wait_done;
        for (int i = 0; i < 40000 && done !== 1'b1; i++) tick(1);
        chk(done, 1'b1);
        tick(120);
        chk(busy, 1'b0);
    endtask : wait_done

    task automatic clr;
        iclr = 1'b1;
        tick(1);
        iclr = 1'b0;
        tick(1);
        chk({irq, nerr, done}, 3'h0);
    endtask : clr

    task automatic test_done;
        $display("checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    // ==========================================================
    // Scenarios
    task automatic t_write;
        int s0;
        s0 = stops;
        gate = 1'b0;
        str = 16'h0BB8;
        hi_min = 99999;
        push('{10'h1A0, 10'h0A5, 10'h05A, 10'h2C3});
        chk(tx_rdy, 1'b0);
        tick(300);
        chk({busy, txe}, 2'h0);
        chk({scl_lv, sda_lv}, 2'h3);
        gate = 1'b1;
        wait_done();
        chk({nerr, irq}, 2'h1);
        chk(i_slave.wr_q.size(), 3);
        chk(i_slave.wr_q[0], 8'hA5);
        chk(i_slave.wr_q[1], 8'h5A);
        chk(i_slave.wr_q[2], 8'hC3);
        i_slave.wr_q.delete();
        chk(hi_min >= 2000, 1'b1);
        chk(hi_ns <= 2100, 1'b1);
        chk(stops - s0, 1);
    endtask : t_write

    task automatic t_nack;
        clr();
        hi = 16'h000A;
        lo = 16'h000A;
        hi_min = 99999;
        push('{10'h1A2, 10'h011, 10'h022, 10'h233});
        wait_done();
        chk(nerr, 1'b1);
        chk(i_slave.wr_q.size(), 0);
        chk(hi_min >= 1260, 1'b1);
        clr();
    endtask : t_nack

    task automatic t_read;
        str = 16'h0000;
        push('{10'h1A1, 10'h000, 10'h0FF, 10'h200});
        wait_done();
        chk(nerr, 1'b0);
        chk({rx_v, rxf}, 2'h2);
        chk(i_slave.mack, 1'b0);
        rxr = 1'b1;
        for (int i = 0; i < 3; i++) begin
            chk(rxd, 8'h3C + 8'(i));
            tick(1);
        end
        rxr = 1'b0;
        chk(rx_v, 1'b0);
        clr();
    endtask : t_read

    task automatic t_restart;
        int s0, a0;
        s0 = stops;
        a0 = starts;
        push('{10'h1A1, 10'h000, 10'h1A0, 10'h255});
        wait_done();
        chk(stops - s0, 1);
        chk(starts - a0, 2);
        chk(i_slave.wr_q.pop_front(), 8'h55);
        chk(i_slave.mack, 1'b0);
        chk({rxd, nerr}, 9'h078);
        rxr = 1'b1;
        tick(1);
        rxr = 1'b0;
        clr();
    endtask : t_restart

    task automatic t_soft;
        gate = 1'b0;
        push('{10'h1A0, 10'h001, 10'h002, 10'h203});
        srst = 1'b1;
        tick(1);
        srst = 1'b0;
        gate = 1'b1;
        tick(200);
        chk({txe, busy, scl_oe, sda_oe}, 4'h8);
    endtask : t_soft

    // ==========================================================
    // Clock, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        {rst, gate, srst, txv, rxr, iclr} = 6'h30;
        txd = 10'h000;
        hi = 16'h0064;
        lo = 16'h0050;
        str = 16'h0000;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        chk({scl_oe, sda_oe, scl_o, sda_o}, 4'h0);
        chk({tx_rdy, txe, rx_v, busy, irq}, 5'h18);
        t_write();
        t_nack();
        t_read();
        t_restart();
        t_soft();
        test_done();
    end

    // Generous bound: all transfers need well under half of it
    initial begin
        #1_500_000;
        errors++;
        test_done();
    end
endmodule : tb_single_master_two_wire_ctrl
